//--- sarh_dev_model.sv
// Behavioural converter on the far side of the host controller's pins.
// Assumes the host keeps pulse and clock spacing; the part has no reset.
`timescale 1ns/1ps

module sarh_dev_model #(
    parameter int CONV_NS = 640
) (
    input  wire logic        convert_start,
    input  wire logic        sck,
    input  wire logic        chain_select,
    input  wire logic        bus_read_enable_or_chain_input,
    input  wire logic [23:0] code_in,
    output logic             busy,
    output logic             sdo
);
    logic [23:0] shreg;
    logic [63:0] acc;
    int          acc_n;
    wire         sdi = chain_select & bus_read_enable_or_chain_input;
    // clock counts only when enabled or chained
    wire         en = chain_select || !bus_read_enable_or_chain_input;

    initial begin
        busy = 1'b0;
        sdo = 1'b0;
        shreg = 24'h000000;
        acc = 64'h0;
        acc_n = 0;
    end

    // convert rise wakes the part, busy spans conversion
    // samples climb by one; mean is visible
    always @(posedge convert_start) begin
        #5 busy = 1'b1;
        #(CONV_NS) busy = 1'b0;
        acc = acc + 64'(code_in) + 64'(acc_n);
        acc_n = acc_n + 1;
        shreg = 24'(acc / 64'(acc_n));
        #5 if (en) sdo = shreg[23];
    end

    // MSB first; chain bit enters behind word
    always @(posedge sck) begin
        if (en) begin
            shreg = {shreg[22:0], sdi};
            acc = 64'h0;
            acc_n = 0;
            #1 sdo = ~sdo;
            #7 sdo = shreg[23];
        end
    end

    // released line shows no stale data
    always @(bus_read_enable_or_chain_input) begin
        if (!chain_select && bus_read_enable_or_chain_input) #13 sdo = ~sdo;
        else if (!chain_select) #16 sdo = shreg[23];
    end
endmodule : sarh_dev_model

//--- sarh_fifo.sv
// Synchronous word FIFO with valid/ready on both sides.
// Assumes one clock; flip-flop storage addressed by index.
`timescale 1ns/1ps

module sarh_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 16
) (
    input  wire logic   clock,
    input  wire logic   rst,
    sarh_stream_if.snk  wr,
    sarh_stream_if.src  rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;

    // Full and empty come straight from the occupancy count
    assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_reg != '0);
    assign rd.data  = mem_reg[rptr_reg];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    // One write enable per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clock) begin
            if (push && wptr_reg == AW'(i)) begin
                mem_reg[i] <= wr.data;
            end
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 :
                            wptr_reg + AW'(1);
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 :
                            rptr_reg + AW'(1);
            end
        end
    end

    // Occupancy
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (push && !pop) begin
            cnt_reg <= cnt_reg + (AW+1)'(1);
        end else if (pop && !push) begin
            cnt_reg <= cnt_reg - (AW+1)'(1);
        end
    end

endmodule : sarh_fifo

//--- sarh_host.sv
// Host controller for a 24-bit sampling converter with averaging filter:
// pulses the convert pin, watches busy, makes the shift clock and reads
// results into a buffer. Assumes the converter's pins are wired directly;
// busy and serial data arrive asynchronously and are synchronised here.
//
// Functional notes
// [RULE1] Convert rising edge starts a conversion
// [RULE2] Busy high during conversion, low after
// [RULE3] Chain select low: shared pin enables output
// [RULE4] Chain select high: shared pin is chain input
// [RULE5] Shared pin low: data presented on output
// [RULE6] Shared pin high: output released, clock ignored
// [RULE7] One bit per rising clock, MSB first
// [RULE8] Result is straight unsigned binary
// [RULE9] Shift clock quiet 10 ns after convert
// [RULE10] Convert low at least 20 ns
// [RULE11] Chain mode clock period at least 13.5 ns
// [RULE12] Chain input captured on rising clock edges
// [RULE13] Shift clock period at least 10 ns
// [RULE14] Each 24-bit code goes through averaging filter
// [RULE15] Filter averages 1 to 65536 results; code takes any 17-bit avg_count up to 131071 without a cap
// [RULE16] Read only after busy falls
// [RULE17] Chain: own word first, then upstream words
`timescale 1ns/1ps

module sarh_host
    import sarh_pkg::*;
#(
    parameter int CHAIN_WORDS = 2,
    parameter int FIFO_DEPTH  = 16,
    parameter int SCK_HALF    = 4
) (
    input  wire logic                           clock,
    input  wire logic                           rst,
    input  wire logic                           conv_req,
    output logic                                conv_ready,
    input  wire logic                           chain_mode,
    input  wire logic [sarh_pkg::AVG_BITS-1:0]  avg_count,
    output logic                                out_valid,
    output logic [sarh_pkg::WORD_BITS-1:0]      out_data,
    input  wire logic                           out_ready,
    output logic                                convert_start,
    input  wire logic                           busy,
    output logic                                sck,
    input  wire logic                           sdo,
    output logic                                chain_select,
    output logic                                bus_read_enable_or_chain_input
);
    import sarh_pkg::*;

    // Shift clock half period never shorter than the pin limits allow
    localparam int HALF = (SCK_HALF > SCK_HALF_MIN) ? SCK_HALF : SCK_HALF_MIN;

    sarh_state_t                state_reg;
    logic [15:0]                tmr_reg;
    logic [15:0]                cyc_reg;
    logic [AVG_BITS-1:0]        avg_left_reg;
    logic                       chain_reg;
    logic [1:0]                 busy_sync_reg;
    logic [1:0]                 sdo_sync_reg;
    logic                       busy_s;
    logic                       sdo_s;
    logic [7:0]                 ph_reg;
    logic [4:0]                 bit_reg;
    logic [15:0]                word_reg;
    logic [WORD_BITS-1:0]       shift_reg;
    logic                       push_pend_reg;
    logic [WORD_BITS-1:0]       push_data_reg;
    logic                       word_done;
    logic [15:0]                words_total;

    sarh_stream_if #(.W(WORD_BITS)) push_if ();
    sarh_stream_if #(.W(WORD_BITS)) pop_if ();

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Busy and serial data cross from the converter; second stage only is read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_sync_reg <= 2'h0;
            sdo_sync_reg  <= 2'h0;
        end else begin
            busy_sync_reg <= {busy_sync_reg[0], busy};
            sdo_sync_reg  <= {sdo_sync_reg[0], sdo};
        end
    end

    assign busy_s = busy_sync_reg[1];
    assign sdo_s  = sdo_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    assign words_total = chain_reg ? 16'(CHAIN_WORDS) : 16'h0001;
    assign word_done   = (state_reg == ST_SHIFT) && !push_pend_reg &&
                         (ph_reg == 8'(2 * HALF - 1)) &&
                         (bit_reg == 5'(WORD_BITS - 1));

    // State and per-state wait timer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            tmr_reg   <= 16'h0000;
        end else begin
            tmr_reg <= tmr_reg + 16'h0001;
            case (state_reg)
                ST_IDLE: begin
                    // [RULE10] Convert low time
                    if (conv_req && tmr_reg >= 16'(CNVL_CYC) &&
                        cyc_reg >= 16'(CYC_CYC)) begin
                        state_reg <= ST_CNV_HI;
                        tmr_reg   <= 16'h0000;
                    end
                end
                ST_CNV_HI: begin
                    if (tmr_reg >= 16'(CNVH_CYC - 1)) begin
                        state_reg <= ST_CONV;
                        tmr_reg   <= 16'h0000;
                    end
                end
                ST_CONV: begin
                    // [RULE16] Wait for busy to fall
                    // [RULE2] Busy marks the conversion
                    if ((tmr_reg >= 16'(BUSYW_CYC) && !busy_s) ||
                        tmr_reg >= 16'(CONV_TMO)) begin
                        tmr_reg <= 16'h0000;
                        // [RULE15] Further pulses feed the average
                        state_reg <= (avg_left_reg > AVG_BITS'(1)) ?
                                     ST_GAP : ST_ENABLE;
                    end
                end
                ST_GAP: begin
                    // [RULE10] Low time and cycle spacing
                    if (tmr_reg >= 16'(CNVL_CYC) &&
                        cyc_reg >= 16'(CYC_CYC)) begin
                        state_reg <= ST_CNV_HI;
                        tmr_reg   <= 16'h0000;
                    end
                end
                ST_ENABLE: begin
                    // [RULE9] Clock held quiet until output is valid
                    if (tmr_reg >= 16'(EN_CYC) &&
                        tmr_reg >= 16'(QUIET_CYC)) begin
                        state_reg <= ST_SHIFT;
                        tmr_reg   <= 16'h0000;
                    end
                end
                ST_SHIFT: begin
                    if (word_done && word_reg == words_total - 16'h0001) begin
                        state_reg <= ST_RELEASE;
                        tmr_reg   <= 16'h0000;
                    end
                end
                ST_RELEASE: begin
                    if (tmr_reg >= 16'(DIS_CYC)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Time since the last convert rising edge, saturating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cyc_reg <= 16'(CYC_CYC);
        end else if (state_reg != ST_CNV_HI && ((state_reg == ST_IDLE &&
                     conv_req) || state_reg == ST_GAP) &&
                     tmr_reg >= 16'(CNVL_CYC) && cyc_reg >= 16'(CYC_CYC)) begin
            cyc_reg <= 16'h0000;
        end else if (cyc_reg != 16'hFFFF) begin
            cyc_reg <= cyc_reg + 16'h0001;
        end
    end

    // Request capture: averaging depth and chain mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            avg_left_reg <= AVG_BITS'(1);
            chain_reg    <= 1'b0;
        end else if (state_reg == ST_IDLE && conv_req) begin
            // [RULE15] Zero requests a single conversion
            avg_left_reg <= (avg_count == '0) ? AVG_BITS'(1) : avg_count;
            chain_reg    <= chain_mode;
        end else if (state_reg == ST_CONV && state_reg != ST_IDLE &&
                     ((tmr_reg >= 16'(BUSYW_CYC) && !busy_s) ||
                      tmr_reg >= 16'(CONV_TMO)) &&
                     avg_left_reg > AVG_BITS'(1)) begin
            avg_left_reg <= avg_left_reg - AVG_BITS'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers

    // [RULE1] Rising convert edge per conversion
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            convert_start <= 1'b0;
        end else begin
            convert_start <= (state_reg == ST_IDLE && conv_req &&
                              tmr_reg >= 16'(CNVL_CYC) &&
                              cyc_reg >= 16'(CYC_CYC)) ||
                             (state_reg == ST_GAP &&
                              tmr_reg >= 16'(CNVL_CYC) &&
                              cyc_reg >= 16'(CYC_CYC)) ||
                             (state_reg == ST_CNV_HI &&
                              tmr_reg < 16'(CNVH_CYC - 1));
        end
    end

    // Mode pin and shared pin; chain input held low as a stable first link
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chain_select                   <= 1'b0;
            bus_read_enable_or_chain_input <= 1'b1;
        end else begin
            // [RULE3] Normal mode selected low
            // [RULE4] Chain mode selected high
            chain_select <= chain_reg;
            // [RULE5] Enable output while reading
            // [RULE6] Release output otherwise
            // [RULE12] Chain input stable at every edge
            bus_read_enable_or_chain_input <= chain_reg ? 1'b0 :
                !(state_reg == ST_ENABLE || state_reg == ST_SHIFT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift clock and capture

    // Clock low first half, high second half; stalls while a word waits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ph_reg  <= 8'h00;
            bit_reg <= 5'h00;
            sck     <= 1'b0;
        end else if (state_reg != ST_SHIFT || push_pend_reg) begin
            ph_reg <= 8'h00;
            sck    <= 1'b0;
            if (state_reg != ST_SHIFT) begin
                bit_reg <= 5'h00;
            end
        end else if (ph_reg == 8'(2 * HALF - 1)) begin
            // [RULE13] Period at least 10 ns
            // [RULE11] Chain period at least 13.5 ns
            ph_reg  <= 8'h00;
            sck     <= 1'b0;
            bit_reg <= word_done ? 5'h00 : bit_reg + 5'h01;
        end else begin
            ph_reg <= ph_reg + 8'h01;
            if (ph_reg == 8'(HALF - 1)) begin
                sck <= 1'b1;
            end
        end
    end

    // [RULE7] Sample before each rising edge, MSB first
    // [RULE8] Code kept as straight binary
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift_reg <= '0;
        end else if (state_reg == ST_SHIFT && !push_pend_reg &&
                     ph_reg == 8'(HALF - 1)) begin
            shift_reg <= {shift_reg[WORD_BITS-2:0], sdo_s};
        end
    end

    // [RULE17] Own word first, upstream words follow
    // [RULE14] Each read word is a filtered code
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            word_reg      <= 16'h0000;
            push_pend_reg <= 1'b0;
            push_data_reg <= '0;
        end else begin
            if (state_reg != ST_SHIFT) begin
                word_reg <= 16'h0000;
            end else if (word_done) begin
                word_reg <= word_reg + 16'h0001;
            end
            // Pending word held until the buffer takes it
            if (word_done) begin
                push_pend_reg <= 1'b1;
                push_data_reg <= shift_reg;
            end else if (push_if.ready) begin
                push_pend_reg <= 1'b0;
            end
        end
    end

    assign push_if.valid = push_pend_reg;
    assign push_if.data  = push_data_reg;

    ////////////////////////////////////////////////////////////////////////
    // Buffer and output stage

    sarh_fifo #(
        .W     (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock (clock),
        .rst   (rst),
        .wr    (push_if.snk),
        .rd    (pop_if.src)
    );

    // Registered output so the user sees flip-flops, not the storage mux
    assign pop_if.ready = !out_valid || out_ready;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop_if.ready) begin
            out_valid <= pop_if.valid;
            if (pop_if.valid) begin
                out_data <= pop_if.data;
            end
        end
    end

    // Ready for a new request only when idle and spacing allows
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            conv_ready <= 1'b0;
        end else begin
            conv_ready <= (state_reg == ST_IDLE) && !conv_req &&
                          tmr_reg >= 16'(CNVL_CYC) &&
                          cyc_reg >= 16'(CYC_CYC);
        end
    end

endmodule : sarh_host

//--- sarh_host_checker.sv
// Pin timing checker for the converter host controller.
// Assumes the 250 MHz clock and a shift clock half period of 4 cycles.
`timescale 1ns/1ps

module sarh_host_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic conv_req,
    input wire logic conv_ready,
    input wire logic convert_start,
    input wire logic busy,
    input wire logic sck,
    input wire logic chain_select,
    input wire logic bus_read_enable_or_chain_input
);
    import sarh_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [7:0] gap_reg;

    // Cycles since the last convert rise; saturates so reset reads as long
    always_ff @(posedge clock or posedge rst) begin
        if (rst) gap_reg <= 8'hFF;
        else if ($rose(convert_start)) gap_reg <= 8'h00;
        else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
    end

    sequence s_cnv_high;
        convert_start [*5];
    endsequence
    sequence s_sck_quiet;
        !sck [*3];
    endsequence

    chk_cnv_pulse: assert property (
        $rose(convert_start) |-> s_cnv_high and s_sck_quiet)
        else $error("convert pulse or quiet time violated");
    chk_cnv_low: assert property (
        $fell(convert_start) |-> !convert_start [*5])
        else $error("convert low time too short");
    chk_cnv_spacing: assert property (
        $rose(convert_start) |-> gap_reg >= 8'(CYC_CYC - 1))
        else $error("conversions closer than one microsecond");
    chk_sck_high: assert property ($rose(sck) |-> sck [*4])
        else $error("shift clock high phase too short");
    chk_sck_low: assert property ($fell(sck) |-> !sck [*4])
        else $error("shift clock low phase too short");
    chk_read_after_busy: assert property (
        $rose(sck) |-> !busy && !$past(busy, 2))
        else $error("shift clock while converter busy");
    chk_enable_read: assert property (
        $rose(sck) && !chain_select |-> !bus_read_enable_or_chain_input)
        else $error("shift clock with data line released");
    chk_chain_input: assert property (
        chain_select |-> !bus_read_enable_or_chain_input)
        else $error("chain input not held low");
    chk_take_req: assert property (
        conv_req && conv_ready |-> ##[1:2] $rose(convert_start))
        else $error("taken request gave no convert edge");
endmodule : sarh_host_checker

bind sarh_host sarh_host_checker u_sarh_host_checker (
    .clock(clock), .rst(rst), .conv_req(conv_req),
    .conv_ready(conv_ready), .convert_start(convert_start), .busy(busy),
    .sck(sck), .chain_select(chain_select),
    .bus_read_enable_or_chain_input(bus_read_enable_or_chain_input));

//--- sarh_pkg.sv
// Constants for the host-side controller of the serial converter.
// Assumes a 250 MHz system clock; all timing counts derive from it.
package sarh_pkg;

    // System clock period in picoseconds
    localparam int CLK_PS        = 4000;

    // Result word and averaging range
    localparam int WORD_BITS     = 24;
    localparam int AVG_BITS      = 17;
    localparam int AVG_MAX       = 65536;

    // Pin timing figures as printed
    localparam int T_CNVH_NS     = 20;
    localparam int T_CNVL_NS     = 20;
    localparam int T_CYC_NS      = 1000;
    localparam int T_BUSYLH_NS   = 13;
    localparam int T_CONV_MAX_NS = 675;
    localparam int T_QUIET_NS    = 10;
    localparam int T_EN_NS       = 16;
    localparam int T_DIS_NS      = 13;
    localparam int T_SCK_NS      = 10;
    localparam int T_SCKCH_PS    = 13500;
    localparam int T_DSDO_MAX_PS = 9500;

    // Two flip-flops of synchroniser delay on every sampled pin
    localparam int SYNC_CYC      = 2;

    // Least times round up to whole cycles
    localparam int CNVH_CYC  = (T_CNVH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CNVL_CYC  = (T_CNVL_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CYC_CYC   = (T_CYC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int BUSYW_CYC = (T_BUSYLH_NS * 1000 + CLK_PS - 1) / CLK_PS
                               + SYNC_CYC;
    localparam int QUIET_CYC = (T_QUIET_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CONV_TMO  = (T_CONV_MAX_NS * 1000 + CLK_PS - 1) / CLK_PS
                               + BUSYW_CYC;
    localparam int EN_CYC    = (T_EN_NS * 1000 + CLK_PS - 1) / CLK_PS
                               + SYNC_CYC;
    localparam int DIS_CYC   = (T_DIS_NS * 1000 + CLK_PS - 1) / CLK_PS;

    // Least half period of the shift clock, the larger of the chain-mode and read-back figures
    localparam int SCK_HALF_N   = (T_SCK_NS * 500 + CLK_PS - 1) / CLK_PS;
    localparam int SCK_HALF_CH  = (T_SCKCH_PS / 2 + CLK_PS - 1) / CLK_PS;
    // Data from the pin needs output delay plus synchroniser before sampling
    localparam int SCK_HALF_RD  = ((T_DSDO_MAX_PS + CLK_PS - 1) / CLK_PS
                                   + SYNC_CYC + 1) / 2 + 1;
    localparam int SCK_HALF_MIN = (SCK_HALF_CH > SCK_HALF_RD) ?
                                  SCK_HALF_CH : SCK_HALF_RD;

    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_CNV_HI  = 7'h02,
        ST_CONV    = 7'h04,
        ST_GAP     = 7'h08,
        ST_ENABLE  = 7'h10,
        ST_SHIFT   = 7'h20,
        ST_RELEASE = 7'h40
    } sarh_state_t;

endpackage : sarh_pkg

//--- sarh_stream_if.sv
// Valid/ready word stream between the sequencer and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface sarh_stream_if #(
    parameter int W = 24
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sarh_stream_if

//--- tb_sarh_host.sv
// Self-checking bench of the host controller against a converter model.
// Assumes the model answers well inside the host's shift clock timing.
`timescale 1ns/1ps

`define CHK(what, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", what, exp, got); end end

module tb_sarh_host;
    import sarh_pkg::*;
    logic                 clock, rst, conv_req, conv_ready, chain_mode;
    logic                 out_valid, convert_start, busy, sck, sdo;
    logic                 chain_select, rd_en_or_chain;
    logic                 out_ready = 1'b0;
    logic [AVG_BITS-1:0]  avg_count;
    logic [WORD_BITS-1:0] out_data, code_in, exp_w;
    logic [WORD_BITS-1:0] exp_q [$];
    logic [AVG_BITS-1:0]  navg [6] = '{17'h1, 17'h0, 17'h2, 17'h5,
                                       17'h10, 17'h3};
    logic [WORD_BITS-1:0] ncode [6] = '{24'hFFFFFF, 24'h123456, 24'h800000,
                                        24'h000000, 24'hFFFFEF, 24'h0F0F0F};
    int                   n_mismatch, samples_checked, cyc, rdy_mode, k, n;
    bit                   ok;

    sarh_host #(.CHAIN_WORDS(2), .FIFO_DEPTH(16), .SCK_HALF(4)) u_sarh_host (
        .clock(clock), .rst(rst), .conv_req(conv_req),
        .conv_ready(conv_ready), .chain_mode(chain_mode),
        .avg_count(avg_count), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready), .convert_start(convert_start), .busy(busy),
        .sck(sck), .sdo(sdo), .chain_select(chain_select),
        .bus_read_enable_or_chain_input(rd_en_or_chain));

    sarh_dev_model u_sarh_dev_model (
        .convert_start(convert_start), .sck(sck),
        .chain_select(chain_select),
        .bus_read_enable_or_chain_input(rd_en_or_chain),
        .code_in(code_in), .busy(busy), .sdo(sdo));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Consumer: held off, always taking, or stalling at random
    always @(negedge clock) begin
        out_ready <= (rdy_mode == 1) || (rdy_mode == 2 && $urandom_range(1));
    end

    // Scoreboard: oldest note against each accepted word
    always @(posedge clock) begin
        if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
            exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : ~out_data;
            `CHK("out_data", exp_w, out_data)
        end
    end

    // Hang guard; the full run needs under half of this
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic pulse_reset();
        rst = 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        `CHK("convert_start", 1'b0, convert_start)
        `CHK("sck", 1'b0, sck)
        `CHK("read enable", 1'b1, rd_en_or_chain)
        rst = 1'b0;
    endtask : pulse_reset

    // One request when the host is ready; the expected words are noted
    task automatic do_req(input logic chm, input logic [AVG_BITS-1:0] na,
                          input logic [WORD_BITS-1:0] code, output bit got);
        int i;
        int eff;
        got = 1'b0;
        eff = (na == 17'h0) ? 1 : int'(na);
        for (i = 0; i < 5000 && conv_ready !== 1'b1; i++) @(negedge clock);
        if (conv_ready === 1'b1) begin
            got = 1'b1;
            chain_mode = chm;
            avg_count = na;
            code_in = code;
            conv_req = 1'b1;
            // mean of code up to code plus count less one
            exp_q.push_back(code + 24'((eff - 1) / 2));
            // own word, then the constant-low chain input
            if (chm) exp_q.push_back(24'h000000);
            @(negedge clock);
            conv_req = 1'b0;
        end
    endtask : do_req

    task automatic wait_drain();
        int i;
        for (i = 0; i < 6000 && exp_q.size() != 0; i++) @(negedge clock);
        `CHK("words left", 0, exp_q.size())
    endtask : wait_drain

    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        cyc = 0;
        rdy_mode = 1;
        conv_req = 1'b0;
        chain_mode = 1'b0;
        avg_count = 17'h1;
        code_in = 24'h000000;
        void'($urandom(32'h9B869A0C));
        pulse_reset();
        // Averaging counts and code boundaries in normal mode
        for (k = 0; k < 6; k++) begin
            do_req(1'b0, navg[k], ncode[k], ok);
            `CHK("taken", 1'b1, ok)
        end
        // Chain mode: two words per request
        do_req(1'b1, 17'h1, 24'($urandom), ok);
        do_req(1'b1, 17'h2, 24'($urandom_range(24'hFFFF00)), ok);
        // Back-to-back requests with a stalling consumer
        rdy_mode = 2;
        for (k = 0; k < 6; k++) begin
            do_req(1'b0, 17'($urandom_range(3, 1)),
                   24'($urandom_range(24'hFFFF00)), ok);
        end
        wait_drain();
        // Fill the buffer until the host stops taking requests
        rdy_mode = 0;
        n = 0;
        for (k = 0; k < 20 && (k == 0 || ok); k++) begin
            do_req(1'b0, 17'h1, 24'($urandom), ok);
            if (ok) n++;
        end
        `CHK("refused when full", 1'b0, ok)
        `CHK("buffer depth", 1'b1, n >= 16)
        rdy_mode = 1;
        wait_drain();
        pulse_reset();
        do_req(1'b0, 17'h1, 24'hA5A5A5, ok);
        wait_drain();
        report_and_stop();
    end
endmodule : tb_sarh_host
